//--- rtl/aads_pkg.sv
// Purpose: Constants for the alarm acknowledgment and dial-out sequencer
// Assumes: 10 MHz clock, APB register access
// Notes:   Register byte offsets, field positions and reset values
package aads_pkg;
	localparam int CLK_HZ          = 10_000_000;
	localparam int TICK_MS         = 1;
	localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	localparam int RING_LIMIT      = 10;
	localparam int APB_AW          = 8;
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_RECOG     = 8'h04;
	localparam logic [7:0] OFS_INTERCALL = 8'h08;
	localparam logic [7:0] OFS_MAXCALLS  = 8'h0C;
	localparam logic [7:0] OFS_RESET_T   = 8'h10;
	localparam logic [7:0] OFS_NUMCOUNT  = 8'h14;
	localparam logic [7:0] OFS_STATUS    = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h1C;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;
	localparam logic [7:0] OFS_KEYACK    = 8'h24;
	localparam int CTRL_ANSDEV_BIT = 0;
	localparam int CTRL_ENABLE_BIT = 1;
	localparam logic [1:0]  CTRL_RST      = 2'h2;
	localparam logic [15:0] RECOG_RST     = 16'h0000;
	localparam logic [15:0] INTERCALL_RST = 16'h0064;
	localparam logic [7:0]  MAXCALLS_RST  = 8'h0A;
	localparam logic [15:0] RESET_T_RST   = 16'h0000;
	localparam logic [3:0]  NUMCOUNT_RST  = 4'h1;
	localparam int IRQ_ALARM   = 0;
	localparam int IRQ_ACK     = 1;
	localparam int IRQ_CALL    = 2;
	localparam int IRQ_REARM   = 3;
	localparam int IRQ_W       = 4;
	typedef enum logic [1:0] {
		AADS_ST_NORMAL  = 2'b00,
		AADS_ST_PENDING = 2'b01,
		AADS_ST_ACKED   = 2'b10,
		AADS_ST_REARMED = 2'b11
	} aads_status_e;
	typedef enum logic [3:0] {
		SQ_IDLE    = 4'b0000,
		SQ_RECOG   = 4'b0001,
		SQ_DIAL    = 4'b0010,
		SQ_RINGOUT = 4'b0011,
		SQ_TALK    = 4'b0100,
		SQ_WAIT    = 4'b0101,
		SQ_CBRING  = 4'b0110,
		SQ_CBTALK  = 4'b0111,
		SQ_ACKED   = 4'b1000,
		SQ_REARM   = 4'b1001
	} aads_seq_e;
endpackage

//--- rtl/aads_seq.sv
// Purpose: Alarm acknowledgment and dial-out sequencer with APB registers
// Assumes: Ring, busy, answer and hook inputs arrive from the line interface pins
// Notes:   Times are in milliseconds, counted on a 1 ms tick enable
`timescale 1ns/100ps
// Overview of operation
// - Callback answered after ten incoming rings
// - Answering-device mode answers on first ring
// - Hang-up after callback acknowledges, stops dial-out
// - Unanswered or machine call: wait, dial next
// - Dial list in order, wrap, stop at max
// - Max calls reached: self-acknowledge, end dial-out
// - Ack with alert present: reset time, redial
// - Reset time zero: never redial acked alarm
// - Outgoing: hang up after ten rings or busy
// - Alarm valid after recognition time persistence
module aads_seq
	import aads_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  srst,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [aads_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Sensor and keypad pins
	input  wire logic                  alert_in,
	input  wire logic                  key_ack_in,
	// Telephone line pins
	input  wire logic                  ring_in,
	input  wire logic                  busy_in,
	input  wire logic                  answered_in,
	input  wire logic                  machine_in,
	input  wire logic                  remote_ack_in,
	input  wire logic                  far_hangup_in,
	// Line control
	output logic                       off_hook,
	output logic                       dial_strobe,
	output logic [3:0]                 dial_index,
	// Status
	output aads_pkg::aads_status_e     status,
	output logic                       irq
);
	import aads_pkg::*;

	// Two-stage synchronisers for pins
	logic [7:0] pin_raw;
	logic [7:0] pin_m_r;
	logic [7:0] pin_s_r;
	logic [7:0] pin_d_r;
	assign pin_raw = {far_hangup_in, remote_ack_in, machine_in, answered_in,
		busy_in, ring_in, key_ack_in, alert_in};
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_m_r <= 8'h00;
			pin_s_r <= 8'h00;
			pin_d_r <= 8'h00;
		end else begin
			pin_m_r <= pin_raw;
			pin_s_r <= pin_m_r;
			pin_d_r <= pin_s_r;
		end
	end
	wire alert    = pin_s_r[0];
	wire key_ack  = pin_s_r[1] & ~pin_d_r[1];
	wire ring_e   = pin_s_r[2] & ~pin_d_r[2];
	wire busy     = pin_s_r[3];
	wire answered = pin_s_r[4];
	wire machine  = pin_s_r[5];
	wire rem_ack  = pin_s_r[6] & ~pin_d_r[6];
	wire far_hang = pin_s_r[7];

	// Millisecond tick divider
	logic [13:0] tick_cnt_r;
	wire         tick = (tick_cnt_r == 14'(TICK_CYCLES - 1));
	always_ff @(posedge clk) begin
		if (srst || tick) begin
			tick_cnt_r <= 14'h0000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 14'h0001;
		end
	end

	// Registers
	logic [1:0]        ctrl_r;
	logic [15:0]       recog_r;
	logic [15:0]       intercall_r;
	logic [7:0]        maxcalls_r;
	logic [15:0]       reset_t_r;
	logic [3:0]        numcount_r;
	logic [IRQ_W-1:0]  irq_stat_r;
	logic [IRQ_W-1:0]  irq_mask_r;
	logic              sw_ack_r;

	// APB decode
	wire acc      = psel & penable;
	wire wr       = acc & pwrite;
	wire hit_ctrl = (paddr == OFS_CTRL);
	wire hit_rcg  = (paddr == OFS_RECOG);
	wire hit_ict  = (paddr == OFS_INTERCALL);
	wire hit_max  = (paddr == OFS_MAXCALLS);
	wire hit_rst  = (paddr == OFS_RESET_T);
	wire hit_num  = (paddr == OFS_NUMCOUNT);
	wire hit_sts  = (paddr == OFS_STATUS);
	wire hit_ist  = (paddr == OFS_IRQ_STAT);
	wire hit_msk  = (paddr == OFS_IRQ_MASK);
	wire hit_key  = (paddr == OFS_KEYACK);
	wire hit_any  = hit_ctrl | hit_rcg | hit_ict | hit_max | hit_rst | hit_num
		| hit_sts | hit_ist | hit_msk | hit_key;

	// Sequencer state
	aads_seq_e    st_r;
	aads_seq_e    st_nxt;
	logic [3:0]   ring_cnt_r;
	logic [7:0]   calls_r;
	logic [3:0]   idx_r;
	logic         acked_r;
	wire          rcg_done;
	wire          ict_done;
	wire          rst_done;
	logic         rcg_load;
	logic         ict_load;
	logic         rst_load;

	wire ack_any    = key_ack | sw_ack_r;
	wire ans_now    = ctrl_r[CTRL_ANSDEV_BIT] ? 1'b1
		: (ring_cnt_r == 4'(RING_LIMIT - 1));
	wire calls_out  = (calls_r >= maxcalls_r);
	wire call_fail  = busy | machine | (ring_e && ring_cnt_r == 4'(RING_LIMIT - 1));

	// Next-state logic
	always_comb begin
		st_nxt   = st_r;
		rcg_load = 1'b0;
		ict_load = 1'b0;
		rst_load = 1'b0;
		case (st_r)
			SQ_IDLE: begin
				if (alert && ctrl_r[CTRL_ENABLE_BIT]) begin
					st_nxt   = SQ_RECOG;
					rcg_load = 1'b1;
				end
			end
			SQ_RECOG: begin
				if (!alert) begin
					st_nxt = SQ_IDLE;
				end else if (rcg_done) begin
					st_nxt = SQ_DIAL;
				end
			end
			SQ_DIAL: begin
				st_nxt = ack_any ? SQ_ACKED : SQ_RINGOUT;
			end
			SQ_RINGOUT: begin
				if (ack_any) begin
					st_nxt = SQ_ACKED;
				end else if (answered && !machine) begin
					st_nxt = SQ_TALK;
				end else if (call_fail) begin
					st_nxt   = SQ_WAIT;
					ict_load = 1'b1;
				end
			end
			SQ_TALK: begin
				if (rem_ack || ack_any) begin
					st_nxt = SQ_ACKED;
				end else if (far_hang) begin
					st_nxt   = SQ_WAIT;
					ict_load = 1'b1;
				end
			end
			SQ_WAIT: begin
				if (ack_any) begin
					st_nxt = SQ_ACKED;
				end else if (ring_e) begin
					st_nxt = ans_now ? SQ_CBTALK : SQ_CBRING;
				end else if (ict_done) begin
					st_nxt = calls_out ? SQ_ACKED : SQ_DIAL;
				end
			end
			SQ_CBRING: begin
				if (ack_any) begin
					st_nxt = SQ_ACKED;
				end else if (ring_e && ans_now) begin
					st_nxt = SQ_CBTALK;
				end else if (ict_done) begin
					st_nxt = calls_out ? SQ_ACKED : SQ_DIAL;
				end
			end
			SQ_CBTALK: begin
				if (far_hang || rem_ack || ack_any) begin
					st_nxt = SQ_ACKED;
				end
			end
			SQ_ACKED: begin
				if (!alert) begin
					st_nxt = SQ_IDLE;
				end else if (reset_t_r != 16'h0000) begin
					st_nxt   = SQ_REARM;
					rst_load = 1'b1;
				end
			end
			SQ_REARM: begin
				if (!alert) begin
					st_nxt = SQ_IDLE;
				end else if (rst_done) begin
					st_nxt = SQ_DIAL;
				end
			end
			default: st_nxt = SQ_IDLE;
		endcase
	end

	// State and call bookkeeping
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= SQ_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Ring counter restarts on every state change; a callback opens on its first ring
	always_ff @(posedge clk) begin
		if (srst) begin
			ring_cnt_r <= 4'h0;
		end else if (st_nxt != st_r) begin
			ring_cnt_r <= (st_nxt == SQ_CBRING) ? 4'h1 : 4'h0;
		end else if (ring_e && ring_cnt_r != 4'hF) begin
			ring_cnt_r <= ring_cnt_r + 4'h1;
		end
	end

	// Calls placed and list position, wrapping over the list
	wire entering_dial = (st_nxt == SQ_DIAL) && (st_r != SQ_DIAL);
	wire fresh_alarm   = (st_r == SQ_RECOG) || (st_r == SQ_REARM);
	always_ff @(posedge clk) begin
		if (srst) begin
			calls_r <= 8'h00;
			idx_r   <= 4'h0;
		end else if (entering_dial && fresh_alarm) begin
			calls_r <= 8'h01;
			idx_r   <= 4'h0;
		end else if (entering_dial) begin
			calls_r <= calls_r + 8'h01;
			idx_r   <= (idx_r + 4'h1 >= numcount_r) ? 4'h0 : idx_r + 4'h1;
		end
	end

	// Acknowledged flag; zero reset time leaves it held
	always_ff @(posedge clk) begin
		if (srst) begin
			acked_r <= 1'b0;
		end else if (st_nxt == SQ_IDLE) begin
			acked_r <= 1'b0;
		end else if (st_nxt == SQ_ACKED) begin
			acked_r <= 1'b1;
		end else if (st_nxt == SQ_DIAL) begin
			acked_r <= 1'b0;
		end
	end

	// Timers
	aads_timer #(.W(16)) u_rcg (
		.clk   (clk),
		.srst  (srst),
		.load  (rcg_load),
		.value (recog_r),
		.tick  (tick),
		.done  (rcg_done)
	);
	aads_timer #(.W(16)) u_ict (
		.clk   (clk),
		.srst  (srst),
		.load  (ict_load),
		.value (intercall_r),
		.tick  (tick),
		.done  (ict_done)
	);
	aads_timer #(.W(16)) u_rst (
		.clk   (clk),
		.srst  (srst),
		.load  (rst_load),
		.value (reset_t_r),
		.tick  (tick),
		.done  (rst_done)
	);

	// Status encoding
	aads_status_e status_nxt;
	always_comb begin
		case (st_nxt)
			SQ_IDLE, SQ_RECOG: status_nxt = AADS_ST_NORMAL;
			SQ_ACKED:          status_nxt = AADS_ST_ACKED;
			SQ_REARM:          status_nxt = AADS_ST_REARMED;
			default:           status_nxt = acked_r ? AADS_ST_REARMED : AADS_ST_PENDING;
		endcase
	end

	// Interrupt events
	wire [IRQ_W-1:0] ev;
	assign ev[IRQ_ALARM] = (st_r == SQ_RECOG) && (st_nxt == SQ_DIAL);
	assign ev[IRQ_ACK]   = (st_r != SQ_ACKED) && (st_nxt == SQ_ACKED);
	assign ev[IRQ_CALL]  = entering_dial;
	assign ev[IRQ_REARM] = (st_r == SQ_REARM) && (st_nxt == SQ_DIAL);
	wire [IRQ_W-1:0] w1c = (wr && hit_ist) ? pwdata[IRQ_W-1:0] : '0;

	// Register writes; events win over write-one clears
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_r      <= CTRL_RST;
			recog_r     <= RECOG_RST;
			intercall_r <= INTERCALL_RST;
			maxcalls_r  <= MAXCALLS_RST;
			reset_t_r   <= RESET_T_RST;
			numcount_r  <= NUMCOUNT_RST;
			irq_stat_r  <= '0;
			irq_mask_r  <= '0;
			sw_ack_r    <= 1'b0;
		end else begin
			if (wr && hit_ctrl) ctrl_r      <= pwdata[1:0];
			if (wr && hit_rcg)  recog_r     <= pwdata[15:0];
			if (wr && hit_ict)  intercall_r <= pwdata[15:0];
			if (wr && hit_max)  maxcalls_r  <= pwdata[7:0];
			if (wr && hit_rst)  reset_t_r   <= pwdata[15:0];
			if (wr && hit_num)  numcount_r  <= pwdata[3:0];
			if (wr && hit_msk)  irq_mask_r  <= pwdata[IRQ_W-1:0];
			irq_stat_r <= (irq_stat_r & ~w1c) | ev;
			sw_ack_r   <= wr && hit_key && pwdata[0];
		end
	end

	// Read mux
	logic [31:0] rd_nxt;
	always_comb begin
		case (1'b1)
			hit_ctrl: rd_nxt = {30'h0, ctrl_r};
			hit_rcg:  rd_nxt = {16'h0, recog_r};
			hit_ict:  rd_nxt = {16'h0, intercall_r};
			hit_max:  rd_nxt = {24'h0, maxcalls_r};
			hit_rst:  rd_nxt = {16'h0, reset_t_r};
			hit_num:  rd_nxt = {28'h0, numcount_r};
			hit_sts:  rd_nxt = {16'h0, calls_r, idx_r, acked_r, 1'b0, status};
			hit_ist:  rd_nxt = {28'h0, irq_stat_r};
			hit_msk:  rd_nxt = {28'h0, irq_mask_r};
			default:  rd_nxt = 32'h0000_0000;
		endcase
	end

	// Outputs from flip-flops; APB answers one cycle after the setup phase, in the first access cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata      <= 32'h0000_0000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			off_hook    <= 1'b0;
			dial_strobe <= 1'b0;
			dial_index  <= 4'h0;
			status      <= AADS_ST_NORMAL;
			irq         <= 1'b0;
		end else begin
			pready      <= psel & ~penable;
			pslverr     <= psel & ~penable & ~hit_any;
			prdata      <= (psel & ~penable & ~pwrite) ? rd_nxt : 32'h0000_0000;
			off_hook    <= (st_nxt == SQ_DIAL) || (st_nxt == SQ_RINGOUT)
				|| (st_nxt == SQ_TALK) || (st_nxt == SQ_CBTALK);
			dial_strobe <= entering_dial;
			dial_index  <= entering_dial ? (fresh_alarm ? 4'h0 :
				((idx_r + 4'h1 >= numcount_r) ? 4'h0 : idx_r + 4'h1)) : idx_r;
			status      <= status_nxt;
			irq         <= |((irq_stat_r & ~w1c | ev) & irq_mask_r);
		end
	end
endmodule

//--- rtl/aads_timer.sv
// Purpose: Loadable down counter stepping on a tick enable
// Assumes: One clock, synchronous active-high reset
// Notes:   done is high while the count stands at zero
`timescale 1ns/100ps
module aads_timer #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Control
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	input  wire logic         tick,
	// Result
	output logic              done
);
	logic [W:0] cnt_r;

	// Load wins over counting; a non-zero load counts one extra tick because
	// the tick runs free and its first pulse may come at once, cutting the wait short
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_r <= '0;
		end else if (load) begin
			cnt_r <= (value == '0) ? '0 : {1'b0, value} + (W+1)'(1);
		end else if (tick && cnt_r != '0) begin
			cnt_r <= cnt_r - (W+1)'(1);
		end
	end

	assign done = (cnt_r == '0);
endmodule

//--- tb/aads_line_model.sv
// Purpose: Telephone line with remote caller for the sequencer
// Assumes: Bench sets mode before each outgoing call
// Notes:   mode 0 rings unanswered, 1 busy, 2 machine or fax
`timescale 1ns/100ps
module aads_line_model (
	// Clock
	input wire logic clk,
	// Line control from the sequencer
	input wire logic off_hook,
	input wire logic dial_strobe,
	// Line status to the sequencer
	output logic     ring_in,
	output logic     busy_in,
	output logic     answered_in,
	output logic     machine_in,
	output logic     remote_ack_in,
	output logic     far_hangup_in
);
	int mode = 0;

	// Idle line at time zero
	initial begin
		{ring_in, busy_in, answered_in} = 3'h0;
		{machine_in, remote_ack_in, far_hangup_in} = 3'h0;
	end

	// Ring pulses of random length
	task automatic ring_burst(input int n);
		for (int i = 0; i < n; i++) begin
			ring_in <= 1'b1;
			repeat ($urandom_range(3, 6)) @(posedge clk);
			ring_in <= 1'b0;
			repeat ($urandom_range(8, 16)) @(posedge clk);
		end
	endtask

	// Hold call progress until the line is released
	task automatic hold_till_onhook();
		for (int i = 0; i < 50000 && off_hook; i++) @(posedge clk);
		{busy_in, answered_in, machine_in, far_hangup_in} <= 4'h0;
	endtask

	// Ack code then far end goes away
	task automatic finish_call();
		remote_ack_in <= 1'b1;
		repeat (4) @(posedge clk);
		remote_ack_in <= 1'b0;
		far_hangup_in <= 1'b1;
		@(posedge clk);
		hold_till_onhook();
	endtask

	// Outgoing call answered as commanded
	always @(posedge clk) begin
		if (dial_strobe) begin
			if (mode == 1)
				busy_in <= 1'b1;
			else if (mode == 2)
				{answered_in, machine_in} <= 2'h3;
			else
				ring_burst(10);
			hold_till_onhook();
		end
	end
endmodule

//--- tb/aads_monitor.sv
// Purpose: Port-level checks on the alarm sequencer
// Assumes: Bound to aads_seq from the bench top file
// Notes:   One clock domain, checks disabled in reset
`timescale 1ns/100ps
module aads_monitor
	import aads_pkg::*;
(
	// Clock and reset
	input wire logic                   clk,
	input wire logic                   srst,
	// Line control and status
	input wire logic                   off_hook,
	input wire logic                   dial_strobe,
	input wire logic [3:0]             dial_index,
	input wire aads_pkg::aads_status_e status
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// Dialling rules
	strobe_hook_a: assert property (dial_strobe |-> off_hook)
		else $error("dial strobe without line seized");
	strobe_pulse_a: assert property (dial_strobe |=> !dial_strobe)
		else $error("dial strobe longer than one cycle");
	index_hold_a: assert property (off_hook && $past(off_hook) |-> $stable(dial_index))
		else $error("dial index moved during a call");
	hangup_wait_a: assert property ($fell(off_hook) |-> !dial_strobe [*8])
		else $error("redial without intercall wait");
	dial_valid_a: assert property (dial_strobe
		|-> status inside {AADS_ST_PENDING, AADS_ST_REARMED})
		else $error("dial without a valid alarm");
	// Status sequence rules
	acked_nodial_a: assert property (status == AADS_ST_ACKED |-> !dial_strobe)
		else $error("dial while acknowledged");
	rearm_src_a: assert property ($changed(status) && status == AADS_ST_REARMED
		|-> $past(status) == AADS_ST_ACKED)
		else $error("rearm not preceded by acknowledge");
	ack_src_a: assert property ($changed(status) && status == AADS_ST_ACKED
		|-> $past(status) inside {AADS_ST_PENDING, AADS_ST_REARMED})
		else $error("acknowledge without an alarm");
	normal_idle_a: assert property (status == AADS_ST_NORMAL
		&& $past(status) == AADS_ST_NORMAL |-> !off_hook)
		else $error("line seized in normal state");

	// Main scenarios
	cover property (dial_strobe);
	cover property ($rose(status == AADS_ST_REARMED));
	cover property ($fell(off_hook) && status == AADS_ST_PENDING);
endmodule

//--- tb/aads_seq_tb_top.sv
// Purpose: Self-checking bench for the alarm sequencer
// Assumes: 1 ms tick, intercall time kept at 1 ms, reset time 0 then 1 ms, recognition time left at 0
// Notes:   Reads and dial strobes checked against queued notes
`timescale 1ns/100ps
module aads_seq_tb_top;
	import aads_pkg::*;
	logic         clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata;
	logic         alert_in, key_ack_in, ring_in, busy_in, answered_in, machine_in;
	logic         remote_ack_in, far_hangup_in, off_hook, dial_strobe, irq;
	logic [3:0]   dial_index;
	aads_status_e status;
	int           err_total, tests_run;
	logic [32:0]  rd_q[$];
	logic [3:0]   dial_q[$];

	aads_seq uut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .alert_in, .key_ack_in, .ring_in, .busy_in, .answered_in, .machine_in,
		.remote_ack_in, .far_hangup_in, .off_hook, .dial_strobe, .dial_index, .status, .irq);
	aads_line_model line (.clk, .off_hook, .dial_strobe, .ring_in, .busy_in, .answered_in,
		.machine_in, .remote_ack_in, .far_hangup_in);

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer, read results noted for the watcher
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] exp);
		int n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr)
			rd_q.push_back(exp);
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (!pready && n < 20);
		if (!pready) begin
			check("pready", 33'h1, 33'h0);
			print_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic hit(input int sel, input logic [1:0] v);
		case (sel)
			0: return status === v;
			1: return off_hook === v[0];
			default: return dial_strobe === 1'b1;
		endcase
	endfunction

	// Bounded wait on status, line state or a dial strobe
	task automatic wait_on(input string what, input int sel, input logic [1:0] v, input int lim);
		int n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!hit(sel, v) && n < lim);
		tests_run++;
		if (!hit(sel, v)) begin
			err_total++;
			$display("ERROR %s expected %h seen timeout", what, v);
			print_verdict();
		end
	endtask

	// Watcher: compares results with the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite)
			check("apb read", rd_q.size() ? rd_q.pop_front() : 33'h0, {pslverr, prdata});
		if (dial_strobe === 1'b1)
			check("dial index", dial_q.size() ? {29'h0, dial_q.pop_front()} : 33'h1FFFFFFFF,
				{29'h0, dial_index});
	end

	initial begin
		void'($urandom(6));
		{psel, penable, pwrite, alert_in, key_ack_in} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		srst = 1'b1;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		// Register reset values and an unmapped place
		apb(0, OFS_CTRL, 0, {31'h0, CTRL_RST});
		apb(0, OFS_RECOG, 0, {17'h0, RECOG_RST});
		apb(0, OFS_INTERCALL, 0, {17'h0, INTERCALL_RST});
		apb(0, OFS_MAXCALLS, 0, {25'h0, MAXCALLS_RST});
		apb(0, OFS_RESET_T, 0, {17'h0, RESET_T_RST});
		apb(0, OFS_NUMCOUNT, 0, {29'h0, NUMCOUNT_RST});
		apb(0, 8'h40, 0, 33'h100000000);
		// Two numbers, three calls: unanswered, busy, machine
		apb(1, OFS_NUMCOUNT, 32'h2, 0);
		apb(1, OFS_MAXCALLS, 32'h3, 0);
		apb(1, OFS_INTERCALL, 32'h1, 0);
		apb(1, OFS_IRQ_MASK, 32'hF, 0);
		dial_q = '{4'h0, 4'h1, 4'h0};
		alert_in <= 1'b1;
		wait_on("call 1", 2, 0, 100);
		check("pending", {31'h0, AADS_ST_PENDING}, {31'h0, status});
		@(posedge clk);
		line.mode = 1;
		wait_on("call 2", 2, 0, 25000);
		@(posedge clk);
		line.mode = 2;
		wait_on("call 3", 2, 0, 25000);
		wait_on("auto ack", 0, AADS_ST_ACKED, 25000);
		check("irq", 33'h1, {32'h0, irq});
		repeat (3000) @(posedge clk);
		check("acked held", {31'h0, AADS_ST_ACKED}, {31'h0, status});
		alert_in <= 1'b0;
		wait_on("normal", 0, AADS_ST_NORMAL, 50);
		apb(1, OFS_IRQ_STAT, 32'hF, 0);
		repeat (3) @(posedge clk);
		check("irq clear", 33'h0, {32'h0, irq});
		// Callback answering, reset-time rearm
		apb(1, OFS_NUMCOUNT, 32'h1, 0);
		apb(1, OFS_MAXCALLS, 32'h8, 0);
		apb(1, OFS_RESET_T, 32'h1, 0);
		dial_q = '{4'h0, 4'h0};
		alert_in <= 1'b1;
		wait_on("call b", 2, 0, 100);
		wait_on("machine hangup", 1, 0, 200);
		line.ring_burst(9);
		check("early answer", 33'h0, {32'h0, off_hook});
		line.ring_burst(1);
		wait_on("tenth ring", 1, 1, 100);
		// Acknowledged lasts one cycle before the rearm, so watch it while the call ends
		fork
			line.finish_call();
			wait_on("callback ack", 0, AADS_ST_ACKED, 100);
		join
		wait_on("rearm", 0, AADS_ST_REARMED, 25000);
		wait_on("redial", 2, 0, 25000);
		apb(1, OFS_CTRL, 32'h3, 0);
		wait_on("hangup 2", 1, 0, 200);
		line.ring_burst(1);
		wait_on("first ring", 1, 1, 100);
		fork
			line.finish_call();
			wait_on("ack 2", 0, AADS_ST_ACKED, 100);
		join
		alert_in <= 1'b0;
		wait_on("normal 2", 0, AADS_ST_NORMAL, 50);
		key_ack_in <= 1'b1;
		repeat (4) @(posedge clk);
		key_ack_in <= 1'b0;
		repeat (4) @(posedge clk);
		check("keypad idle", {31'h0, AADS_ST_NORMAL}, {31'h0, status});
		check("notes left", 33'h0, {1'b0, 32'(dial_q.size() + rd_q.size())});
		print_verdict();
	end
endmodule

bind aads_seq aads_monitor mon (.clk, .srst, .off_hook, .dial_strobe, .dial_index, .status);
